// *** design/uds_pkg.sv ***
// Constants, field layouts and types for the serial data port and receive status block.
// Assumes a single 40 MHz clock and that every user of these names writes uds_pkg::name.
package uds_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map and fields.
	localparam logic [31:0] DATA_ADDR = 32'h808C_0000;
	localparam logic [31:0] STAT_ADDR = 32'h808C_0004;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam int STS_OE_BIT = 3;
	localparam int STS_BRK_BIT = 2;
	localparam int STS_PAR_BIT = 1;
	localparam int STS_FRM_BIT = 0;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes and bit timing.
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic LINE_IDLE = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef struct packed {
		logic brk;
		logic par;
		logic frm;
		logic [DATA_W-1:0] data;
	} uds_rx_entry_type;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uds_tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} uds_rx_state_type;

endpackage

// *** design/uds_uart_data_rx_status.sv ***
// Serial data port with transmit and receive FIFOs, framing, and the receive error status register.
// Assumes line settings come from same-clock logic, the register port is APB style on clk,
// and the DMA engine does the packing of bytes into words on its own side.
`timescale 1ns/100ps

module uds_uart_data_rx_status #(
	parameter int TX_DEPTH = uds_pkg::FIFO_DEPTH,
	parameter int RX_DEPTH = uds_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	// Line settings
	input wire logic fifo_mode_select,
	input wire logic parity_on,
	input wire logic even_parity_select,
	input wire logic hdlc_sync_mode,
	input wire logic [15:0] baud_div,
	// Serial line
	input wire logic rxd,
	output logic txd,
	// DMA byte path
	input wire logic dma_tx_valid,
	input wire logic [7:0] dma_tx_data,
	output logic dma_tx_ready,
	output logic dma_rx_valid,
	output logic [7:0] dma_rx_data,
	input wire logic dma_rx_ready
);

	localparam int TXP = $clog2(TX_DEPTH);
	localparam int RXP = $clog2(RX_DEPTH);
	localparam logic [TXP:0] TX_FULL = (TXP+1)'(TX_DEPTH);
	localparam logic [RXP:0] RX_FULL = (RXP+1)'(RX_DEPTH);

	// Pointers wrap by overflow, so depths must be powers of two.
	if (TX_DEPTH < 2 || RX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad
		$error("FIFO depths must be powers of two, at least 2");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oversampling tick and receive line synchroniser.
	logic [15:0] div_cnt;
	logic tick, rxd_meta, rxd_s;
	// A zero divisor stops the tick, so no character moves in either direction.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			div_cnt <= (baud_div == 16'h0000 || div_cnt == baud_div) ? 16'h0000 : div_cnt + 16'h0001;
			tick <= baud_div != 16'h0000 && div_cnt == baud_div;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxd_meta <= uds_pkg::LINE_IDLE;
			rxd_s <= uds_pkg::LINE_IDLE;
		end else begin
			rxd_meta <= rxd;
			rxd_s <= rxd_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port decode.
	wire logic hit_data = paddr == uds_pkg::DATA_ADDR;
	wire logic hit_stat = paddr == uds_pkg::STAT_ADDR;
	wire logic apb_go = psel & penable & pready;
	wire logic apb_setup = psel & ~penable;
	wire logic data_wr_pend = psel & hit_data & pwrite;
	wire logic data_rd_pend = psel & hit_data & ~pwrite;
	wire logic data_wr_go = apb_go & hit_data & pwrite;
	wire logic data_rd_go = apb_go & hit_data & ~pwrite;
	wire logic stat_wr_go = apb_go & hit_stat & pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer between the writers and the transmit FIFO.
	logic [7:0] buf_mem [2];
	logic buf_wr, buf_rd;
	logic [1:0] buf_cnt;
	logic [7:0] tx_mem [TX_DEPTH];
	logic [TXP-1:0] tx_wr, tx_rd;
	logic [TXP:0] tx_cnt;
	uds_pkg::uds_tx_state_type tx_state;
	wire logic dma_tx_fire = dma_tx_valid & dma_tx_ready;
	wire logic buf_push = data_wr_go | dma_tx_fire;
	wire logic [7:0] buf_in = data_wr_go ? pwdata[7:0] : dma_tx_data;
	wire logic [TXP:0] tx_limit = fifo_mode_select ? TX_FULL : (TXP+1)'(1);
	wire logic buf_pop = buf_cnt != 2'h0 && tx_cnt < tx_limit;
	wire logic [1:0] next_buf_cnt = buf_cnt + 2'(buf_push) - 2'(buf_pop);
	wire logic tx_load = tx_state == uds_pkg::TX_IDLE && tx_cnt != '0;
	wire logic [TXP:0] next_tx_cnt = tx_cnt + (TXP+1)'(buf_pop) - (TXP+1)'(tx_load);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buf_wr <= 1'b0;
			buf_rd <= 1'b0;
			buf_cnt <= 2'h0;
			tx_wr <= '0;
			tx_rd <= '0;
			tx_cnt <= '0;
		end else begin
			buf_wr <= buf_wr ^ buf_push;
			buf_rd <= buf_rd ^ buf_pop;
			buf_cnt <= next_buf_cnt;
			tx_wr <= tx_wr + TXP'(buf_pop);
			tx_rd <= tx_rd + TXP'(tx_load);
			tx_cnt <= next_tx_cnt;
		end
	end
	always_ff @(posedge clk) begin
		if (buf_push) begin
			buf_mem[buf_wr] <= buf_in;
		end
		if (buf_pop) begin
			tx_mem[tx_wr] <= buf_mem[buf_rd];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter: start, eight data bits, optional parity, one stop bit.
	logic [3:0] tx_ticks;
	logic [2:0] tx_bits;
	logic [7:0] tx_shift;
	logic tx_par;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_state <= uds_pkg::TX_IDLE;
			tx_ticks <= 4'h0;
			tx_bits <= 3'h0;
			tx_shift <= 8'h00;
			tx_par <= 1'b0;
			txd <= uds_pkg::LINE_IDLE;
		end else if (tx_load) begin
			tx_state <= uds_pkg::TX_START;
			tx_ticks <= 4'h0;
			tx_bits <= 3'h0;
			tx_shift <= tx_mem[tx_rd];
			tx_par <= ^tx_mem[tx_rd] ^ ~even_parity_select;
			txd <= 1'b0;
		end else if (tick && tx_state != uds_pkg::TX_IDLE) begin
			tx_ticks <= tx_ticks + 4'h1;
			if (tx_ticks == uds_pkg::TICK_LAST) begin
				case (tx_state)
					uds_pkg::TX_START: begin
						tx_state <= uds_pkg::TX_DATA;
						txd <= tx_shift[0];
					end
					uds_pkg::TX_DATA: begin
						tx_shift <= tx_shift >> 1;
						tx_bits <= tx_bits + 3'h1;
						if (tx_bits != uds_pkg::BIT_LAST) begin
							txd <= tx_shift[1];
						end else if (parity_on) begin
							tx_state <= uds_pkg::TX_PARITY;
							txd <= tx_par;
						end else begin
							tx_state <= uds_pkg::TX_STOP;
							txd <= uds_pkg::LINE_IDLE;
						end
					end
					uds_pkg::TX_PARITY: begin
						tx_state <= uds_pkg::TX_STOP;
						txd <= uds_pkg::LINE_IDLE;
					end
					default: begin
						tx_state <= uds_pkg::TX_IDLE;
						txd <= uds_pkg::LINE_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver: samples mid-bit, sixteen ticks per bit.
	uds_pkg::uds_rx_state_type rx_state;
	logic [3:0] rx_ticks;
	logic [2:0] rx_bits;
	logic [7:0] rx_shift;
	logic rx_par_acc, rx_all_low;
	wire logic rx_bit_end = tick && rx_ticks == uds_pkg::TICK_LAST;
	wire logic rx_stop_sample = rx_bit_end && rx_state == uds_pkg::RX_STOP;
	// A line held low through start, data, parity and stop is a break, not a framing error.
	wire logic rx_brk = rx_all_low & ~rxd_s;
	wire uds_pkg::uds_rx_entry_type rx_word = '{
		brk: rx_brk,
		par: ~rx_brk & parity_on & (rx_par_acc ^ ~even_parity_select),
		frm: ~rx_brk & ~rxd_s,
		data: rx_brk ? 8'h00 : rx_shift
	};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_state <= uds_pkg::RX_IDLE;
			rx_ticks <= 4'h0;
			rx_bits <= 3'h0;
			rx_shift <= 8'h00;
			rx_par_acc <= 1'b0;
			rx_all_low <= 1'b0;
		end else begin
			if (tick) begin
				rx_ticks <= rx_ticks + 4'h1;
			end
			case (rx_state)
				uds_pkg::RX_IDLE: begin
					rx_ticks <= 4'h0;
					if (!rxd_s) begin
						rx_state <= uds_pkg::RX_START;
					end
				end
				uds_pkg::RX_START: begin
					if (tick && rx_ticks == uds_pkg::TICK_MID) begin
						rx_state <= rxd_s ? uds_pkg::RX_IDLE : uds_pkg::RX_DATA;
						rx_ticks <= 4'h0;
						rx_bits <= 3'h0;
						rx_par_acc <= 1'b0;
						rx_all_low <= 1'b1;
					end
				end
				uds_pkg::RX_DATA, uds_pkg::RX_PARITY: begin
					if (rx_bit_end) begin
						rx_par_acc <= rx_par_acc ^ rxd_s;
						rx_all_low <= rx_all_low & ~rxd_s;
						if (rx_state == uds_pkg::RX_DATA) begin
							rx_shift <= {rxd_s, rx_shift[7:1]};
							rx_bits <= rx_bits + 3'h1;
							if (rx_bits == uds_pkg::BIT_LAST) begin
								rx_state <= parity_on ? uds_pkg::RX_PARITY : uds_pkg::RX_STOP;
							end
						end else begin
							rx_state <= uds_pkg::RX_STOP;
						end
					end
				end
				uds_pkg::RX_STOP: begin
					if (rx_bit_end) begin
						rx_state <= rx_brk ? uds_pkg::RX_BREAK : uds_pkg::RX_IDLE;
					end
				end
				default: begin
					if (rxd_s) begin
						rx_state <= uds_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive FIFO of data plus status, and the receive error status register.
	uds_pkg::uds_rx_entry_type rx_mem [RX_DEPTH];
	logic [RXP-1:0] rx_wr, rx_rd;
	logic [RXP:0] rx_cnt;
	logic sts_oe, sts_brk, sts_par, sts_frm;
	wire logic [RXP:0] rx_limit = fifo_mode_select ? RX_FULL : (RXP+1)'(1);
	wire logic rx_full = rx_cnt >= rx_limit;
	wire logic rx_push = rx_stop_sample & ~rx_full;
	wire logic overrun_evt = rx_stop_sample & rx_full;
	wire logic rx_pop = (data_rd_go | (dma_rx_valid & dma_rx_ready)) & rx_cnt != '0;
	wire logic [RXP:0] next_rx_cnt = rx_cnt + (RXP+1)'(rx_push) - (RXP+1)'(rx_pop);
	wire logic [RXP-1:0] next_rx_rd = rx_rd + RXP'(rx_pop);
	wire uds_pkg::uds_rx_entry_type rx_head = rx_mem[rx_rd];
	wire logic head_from_line = rx_cnt == '0 || (rx_cnt == (RXP+1)'(1) && rx_pop);
	wire uds_pkg::uds_rx_entry_type next_head = head_from_line ? rx_word : rx_mem[next_rx_rd];
	// Overrun set wins over a clearing write in the same cycle.
	wire logic next_oe = overrun_evt | (sts_oe & ~stat_wr_go);
	wire logic next_brk = rx_pop ? rx_head.brk : sts_brk & ~stat_wr_go;
	wire logic next_par = rx_pop ? rx_head.par : sts_par & ~stat_wr_go;
	wire logic next_frm = rx_pop ? rx_head.frm : sts_frm & ~stat_wr_go;
	// Synchronous HDLC has no character framing, so only overrun is reported there.
	wire logic [3:0] sts_view = {next_oe, {next_brk, next_par, next_frm} & {3{~hdlc_sync_mode}}};
	wire logic [31:0] rd_value = pwrite ? uds_pkg::REG_RESET :
		hit_data ? {24'h000000, next_head.data} :
		hit_stat ? {28'h0000000, sts_view} : uds_pkg::REG_RESET;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_wr <= '0;
			rx_rd <= '0;
			rx_cnt <= '0;
			sts_oe <= 1'b0;
			sts_brk <= 1'b0;
			sts_par <= 1'b0;
			sts_frm <= 1'b0;
		end else begin
			rx_wr <= rx_wr + RXP'(rx_push);
			rx_rd <= next_rx_rd;
			rx_cnt <= next_rx_cnt;
			sts_oe <= next_oe;
			sts_brk <= next_brk;
			sts_par <= next_par;
			sts_frm <= next_frm;
		end
	end
	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wr] <= rx_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered port outputs.
	// The DMA read side is held off while a register read of the data port is open,
	// so the two readers never take the same entry twice.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= uds_pkg::REG_RESET;
			pready <= 1'b0;
			dma_tx_ready <= 1'b0;
			dma_rx_valid <= 1'b0;
			dma_rx_data <= 8'h00;
		end else begin
			if (apb_setup) begin
				prdata <= rd_value;
			end
			pready <= psel & ~apb_go & (~data_wr_pend | next_buf_cnt < uds_pkg::BUF_DEPTH);
			dma_tx_ready <= next_buf_cnt < uds_pkg::BUF_DEPTH && !data_wr_pend;
			dma_rx_valid <= next_rx_cnt != '0 && !data_rd_pend;
			dma_rx_data <= next_head.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_break_char;
		rx_stop_sample && rx_brk;
	endsequence
	sequence s_stat_setup;
		apb_setup && hit_stat && !pwrite;
	endsequence
	chk_fifo_write_push: assert property (data_wr_go && buf_cnt == 2'h0 && !buf_pop |=> buf_cnt == 2'h1)
		else $error("data write did not enter the transmit path");
	chk_char_start: assert property (tx_load |=> tx_state == uds_pkg::TX_START && !txd ##1 !txd)
		else $error("frame did not open with a start bit");
	chk_parity_bit: assert property (tx_state == uds_pkg::TX_PARITY |-> parity_on ##0 txd == tx_par)
		else $error("parity bit wrong on the line");
	chk_rx_push_count: assert property (rx_push && !rx_pop |=> rx_cnt == $past(rx_cnt) + (RXP+1)'(1))
		else $error("received character not stored");
	chk_char_mode_depth: assert property (!fifo_mode_select && rx_cnt == (RXP+1)'(1) && !rx_pop && rx_stop_sample
		|=> sts_oe && rx_cnt == (RXP+1)'(1))
		else $error("character mode held more than one entry");
	chk_status_follows: assert property (rx_pop |=> {sts_brk, sts_par, sts_frm} ==
		{$past(rx_head.brk), $past(rx_head.par), $past(rx_head.frm)})
		else $error("status not latched from popped entry");
	chk_status_clear: assert property (stat_wr_go && !overrun_evt && !rx_pop
		|=> !sts_oe && !sts_brk && !sts_par && !sts_frm)
		else $error("status write did not clear errors");
	chk_overrun_keeps: assert property (overrun_evt && !rx_pop |=> sts_oe && rx_cnt == $past(rx_cnt))
		else $error("overrun changed FIFO contents or missed flag");
	chk_break_once: assert property (s_break_char |-> rx_word.data == 8'h00 ##1
		rx_state == uds_pkg::RX_BREAK || rx_state == uds_pkg::RX_IDLE)
		else $error("break not handled as one zero character");
	chk_stop_framing: assert property (rx_push && rxd_s |=> !rx_mem[$past(rx_wr)].frm)
		else $error("framing flag set with a valid stop bit");
	chk_sync_mask: assert property (s_stat_setup and hdlc_sync_mode |=> prdata[2:0] == 3'h0)
		else $error("character errors shown in synchronous mode");

endmodule

// *** verif/uds_line_partner.sv ***
// Remote serial station: sends frames on the receive line and collects frames seen on the transmit line.
// Assumes the device clock is also the reference clock, so one bit lasts BIT_CLKS clock cycles.
`timescale 1ns/100ps

module uds_line_partner #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic clk,
	// Frame settings shared with the device
	input wire logic par_on,
	input wire logic even_sel,
	// Serial line
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got[$];
	logic [7:0] d;
	int i;

	initial rxd = 1'b1;

	////////////////////////////////////////
	// A break holds the line low for a whole frame and two bits more, so the receiver must wait for marking.
	task automatic send(input logic [7:0] b, input logic bad_par, input logic stp, input logic brk);
		int k;
		rxd <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk);
		for (k = 0; k < 8; k++) begin
			rxd <= b[k] & ~brk;
			repeat (BIT_CLKS) @(posedge clk);
		end
		if (par_on) begin
			rxd <= ((even_sel ? ^b : ~^b) ^ bad_par) & ~brk;
			repeat (BIT_CLKS) @(posedge clk);
		end
		rxd <= stp & ~brk;
		repeat (BIT_CLKS) @(posedge clk);
		if (brk)
			repeat (2 * BIT_CLKS) @(posedge clk);
		rxd <= 1'b1;
		repeat (2 * BIT_CLKS) @(posedge clk);
	endtask

	////////////////////////////////////////
	// Each collected entry holds the stop bit above the data byte, so a missing stop shows in the compare.
	always begin
		@(negedge txd);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			d[i] = txd;
		end
		repeat (BIT_CLKS * (1 + par_on)) @(posedge clk);
		got.push_back({txd, d});
	end
endmodule

// *** verif/uds_uart_data_rx_status_test.sv ***
// Self-checking bench for the serial data port and receive status block.
// Assumes the line partner model drives the receive line and collects transmitted frames.
`timescale 1ns/100ps

module uds_uart_data_rx_status_test;
	localparam logic [31:0] DA = uds_pkg::DATA_ADDR;
	localparam logic [31:0] SA = uds_pkg::STAT_ADDR;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
	logic pready, txd, rxd, dma_tx_ready, dma_rx_valid;
	logic fms = 1'b1, par = 1'b0, even_sel = 1'b0, hdlc = 1'b0, dma_tx_valid = 1'b0, dma_rx_ready = 1'b0;
	logic [7:0] dma_tx_data = 8'h00, dma_rx_data;
	int miscompares = 0, checks = 0, cycles = 0;

	// A divisor of one gives 32 clocks a bit, the fastest rate the reference clock allows.
	uds_uart_data_rx_status #(.TX_DEPTH(4), .RX_DEPTH(4)) dut_u (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.fifo_mode_select(fms), .parity_on(par), .even_parity_select(even_sel), .hdlc_sync_mode(hdlc),
		.baud_div(16'h0001),
		.rxd(rxd), .txd(txd), .dma_tx_valid(dma_tx_valid), .dma_tx_data(dma_tx_data),
		.dma_tx_ready(dma_tx_ready), .dma_rx_valid(dma_rx_valid), .dma_rx_data(dma_rx_data),
		.dma_rx_ready(dma_rx_ready));
	uds_line_partner #(.BIT_CLKS(32)) lp (.clk(clk), .par_on(par), .even_sel(even_sel), .txd(txd), .rxd(rxd));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			results();
		end
	end

	////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// The request is held until pready is seen high, and completes at the following rising edge.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(negedge clk);
		while (pready !== 1'b1) @(negedge clk);
		r = prdata;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(r, exp);
	endtask

	task rst_pulse;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
	endtask

	////////////////////////////////////////
	task t_reset;
		rd(DA, 32'h0);
		rd(SA, 32'h0);
		rd(32'h808C_0040, 32'h0);
		$display("test reset done");
	endtask

	task t_rx;
		par <= 1'b1;
		even_sel <= 1'b1;
		lp.send(8'hA5, 1'b0, 1'b1, 1'b0);
		lp.send(8'h3C, 1'b1, 1'b1, 1'b0);
		lp.send(8'h00, 1'b0, 1'b0, 1'b1);
		lp.send(8'h5A, 1'b0, 1'b1, 1'b0);
		rd(DA, 32'hA5);
		rd(SA, 32'h0);
		rd(DA, 32'h3C);
		rd(SA, 32'h2);
		bus(1'b1, SA, 32'hFFFF_FFFF);
		rd(SA, 32'h0);
		rd(DA, 32'h0);
		rd(SA, 32'h4);
		rd(DA, 32'h5A);
		rd(SA, 32'h0);
		lp.send(8'h81, 1'b0, 1'b0, 1'b0);
		rd(DA, 32'h81);
		rd(SA, 32'h1);
		$display("test rx done");
	endtask

	// The framing fault above may leave a resync character behind, so reset clears it first.
	task t_overrun;
		rst_pulse();
		fms <= 1'b0;
		even_sel <= 1'b0;
		lp.send(8'h11, 1'b0, 1'b1, 1'b0);
		lp.send(8'h22, 1'b0, 1'b1, 1'b0);
		rd(DA, 32'h11);
		rd(SA, 32'h8);
		bus(1'b1, SA, 32'h0);
		rd(SA, 32'h0);
		$display("test overrun done");
	endtask

	task t_hdlc;
		fms <= 1'b1;
		even_sel <= 1'b1;
		hdlc <= 1'b1;
		lp.send(8'h77, 1'b1, 1'b1, 1'b0);
		rd(DA, 32'h77);
		rd(SA, 32'h0);
		hdlc <= 1'b0;
		rd(SA, 32'h2);
		$display("test hdlc done");
	endtask

	task t_tx;
		par <= 1'b0;
		lp.got.delete();
		bus(1'b1, DA, 32'hFFFF_FF12);
		bus(1'b1, DA, 32'h0000_0034);
		while (lp.got.size() < 2) @(posedge clk);
		fms <= 1'b0;
		par <= 1'b1;
		bus(1'b1, DA, 32'h0000_0056);
		while (lp.got.size() < 3) @(posedge clk);
		check({23'h0, lp.got[0]}, 32'h112);
		check({23'h0, lp.got[1]}, 32'h134);
		check({23'h0, lp.got[2]}, 32'h156);
		$display("test tx done");
	endtask

	task t_dma;
		logic [7:0] b;
		int stalls;
		stalls = 0;
		fms <= 1'b1;
		par <= 1'b0;
		lp.got.delete();
		for (b = 8'hC0; b < 8'hC9; b++) begin
			@(posedge clk);
			dma_tx_valid <= 1'b1;
			dma_tx_data <= b;
			@(negedge clk);
			while (dma_tx_ready !== 1'b1) begin
				stalls++;
				@(negedge clk);
			end
		end
		@(posedge clk);
		dma_tx_valid <= 1'b0;
		check({31'h0, stalls != 0}, 32'h1);
		while (lp.got.size() < 9) @(posedge clk);
		for (b = 8'hC0; b < 8'hC9; b++)
			check({23'h0, lp.got[b - 8'hC0]}, {23'h1, b});
		lp.send(8'h9E, 1'b0, 1'b1, 1'b0);
		@(negedge clk);
		check({31'h0, dma_rx_valid}, 32'h1);
		check({24'h0, dma_rx_data}, 32'h9E);
		@(posedge clk);
		dma_rx_ready <= 1'b1;
		@(posedge clk);
		dma_rx_ready <= 1'b0;
		@(negedge clk);
		check({31'h0, dma_rx_valid}, 32'h0);
		$display("test dma done");
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_rx();
		t_overrun();
		t_hdlc();
		t_tx();
		t_dma();
		results();
	end
endmodule
